// *** src/rtccs_pkg.sv ***
// Notes on behaviour
// - Clock out runs if either disable clear, pin high.
// - Test bit zero normal, one test mode.
// - Select 000 keeps interrupt high, 001 low.
// - Select 010/011 give 2 Hz/1 Hz square wave.
// - Select 1xx asserts level per second/minute/hour/month.
// - Level assertion follows the seconds increment.
// - Adjustment stretches (positive) or shortens (negative) low phase every twenty seconds.
// - Seconds increment trails pulse falling edge ~92 us.
// - Seconds write clears divider, drives interrupt low in 2 Hz/1 Hz select.
// - After power loss status reads halt flag only.
// - Threshold select: zero 2.1 V, one 1.6 V.
// - Low-voltage flag sticks; write zero clears, rearms.
// - Scratch bit read/write, cleared by halt flag.
// - Halt flag sets on oscillator stop, sticks.
// - Halt detection only while chip enable low.
// - Halt clears adjustment and both control registers.
// - Writing zero clears halt flag; one ignored.
// - Periodic flag mirrors periodic interrupt drive.
// - Level mode: writing zero releases until next period.
// - Enabled alarm flag sets ~61 us after match.
// - Writing zero releases alarm until next match.
// - Alarm flag reads zero while its enable clear.
// - Alarm enable bits gate alarms, default off.
package rtccs_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [3:0] RTCCS_ADDR_SECONDS = 4'h0;
  localparam logic [3:0] RTCCS_ADDR_CTRL_ONE = 4'he;
  localparam logic [3:0] RTCCS_ADDR_CTRL_TWO = 4'hf;
  localparam logic [7:0] RTCCS_RD_UNMAPPED  = 8'h00;

  // ------------------------------------------------------------------
  // Timing, given in microseconds and seconds; the microsecond figures are converted to crystal periods
  // ------------------------------------------------------------------
  localparam int unsigned RTCCS_XTAL_HZ       = 32768;
  localparam int unsigned RTCCS_US_PER_S      = 1000000;
  localparam int unsigned RTCCS_SEC_DELAY_US  = 92;
  localparam int unsigned RTCCS_ALARM_DLY_US  = 61;
  localparam int unsigned RTCCS_ADJ_MAX_US    = 3784;
  localparam int unsigned RTCCS_ADJ_PERIOD_S  = 20;
  localparam int unsigned RTCCS_DIV_WIDTH     = 15;
  localparam int unsigned RTCCS_SEC_DELAY_TICKS =
    (RTCCS_SEC_DELAY_US * RTCCS_XTAL_HZ + RTCCS_US_PER_S / 2) / RTCCS_US_PER_S;
  localparam int unsigned RTCCS_ALARM_DLY_TICKS =
    (RTCCS_ALARM_DLY_US * RTCCS_XTAL_HZ + RTCCS_US_PER_S / 2) / RTCCS_US_PER_S;
  localparam int unsigned RTCCS_ADJ_MAX_TICKS =
    (RTCCS_ADJ_MAX_US * RTCCS_XTAL_HZ) / RTCCS_US_PER_S;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    RTCCS_PER_OFF, RTCCS_PER_LOW, RTCCS_PER_2HZ, RTCCS_PER_1HZ,
    RTCCS_PER_SEC, RTCCS_PER_MIN, RTCCS_PER_HOUR, RTCCS_PER_MONTH
  } rtccs_per_sel_t;

  typedef struct packed {
    logic           weekly_alarm_enable;
    logic           daily_alarm_enable;
    logic           hour_24;
    logic           clock_out_disable_b;
    logic           test_mode;
    rtccs_per_sel_t periodic_select;
  } rtccs_ctrl_one_t;

  typedef struct packed {
    logic voltage_threshold_select;
    logic low_voltage_flag;
    logic scratch;
    logic oscillator_halt_flag;
    logic clock_out_disable_a;
    logic periodic_interrupt_flag;
    logic weekly_alarm_flag;
    logic daily_alarm_flag;
  } rtccs_ctrl_two_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rtccs_reg_req_t;

  typedef struct packed {
    logic second_zero;
    logic minute_zero;
    logic hour_zero;
    logic month_first;
  } rtccs_cal_t;

  localparam rtccs_ctrl_one_t RTCCS_CTRL_ONE_RST = 8'h00;
  localparam rtccs_ctrl_two_t RTCCS_CTRL_TWO_RST = 8'h10;

endpackage

// *** src/rtccs_alarm_flag.sv ***
`timescale 1ns/1ps
module rtccs_alarm_flag
  import rtccs_pkg::*;
#(
  parameter int unsigned DELAY_TICKS = RTCCS_ALARM_DLY_TICKS
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic step,
  input  wire logic match,
  input  wire logic enable,
  input  wire logic kill,
  input  wire logic clear_req,
  output logic      flag
);

  if (DELAY_TICKS < 1 || DELAY_TICKS > 15) begin : g_chk
    $error("alarm delay out of range");
  end

  logic [3:0] dly_q;
  logic       flag_q;
  logic       set_now;

  assign set_now = step && dly_q == 4'h1;

  always_ff @(posedge clk) begin
    if (rst || kill || !enable) begin
      dly_q <= 4'h0;
    end else if (match) begin
      dly_q <= 4'(DELAY_TICKS);
    end else if (step && dly_q != 4'h0) begin
      dly_q <= dly_q - 4'h1;
    end
  end

  // Set wins over a clearing write landing in the same cycle.
  always_ff @(posedge clk) begin
    if (rst || kill || !enable) begin
      flag_q <= 1'b0;
    end else if (set_now) begin
      flag_q <= 1'b1;
    end else if (clear_req) begin
      flag_q <= 1'b0;
    end
  end

  assign flag = flag_q && enable;

  chk_flag_gated: assert property (@(posedge clk) disable iff (rst)
    !enable |=> !flag_q) else $error("alarm flag kept while disabled");

endmodule // rtccs_alarm_flag

// *** src/rtccs_top.sv ***
`timescale 1ns/1ps
module rtccs_top
  import rtccs_pkg::*;
#(
  parameter int unsigned DIV_WIDTH     = RTCCS_DIV_WIDTH,
  parameter int unsigned ADJ_MAX_TICKS = RTCCS_ADJ_MAX_TICKS
) (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire rtccs_reg_req_t  reg_req,
  output logic [7:0]           reg_rdata,
  input  wire logic            xtal_clk_pin,
  input  wire logic            clock_out_control_pin,
  input  wire logic            chip_enable_pin,
  input  wire logic            osc_halt_sense_pin,
  input  wire logic            supply_below_2v1_pin,
  input  wire logic            supply_below_1v6_pin,
  input  wire rtccs_cal_t      cal,
  input  wire logic            weekly_alarm_match,
  input  wire logic            daily_alarm_match,
  input  wire logic            adj_active,
  input  wire logic [7:0]      adj_ticks,
  output logic                 crystal_clock_out_pin,
  output logic                 interrupt_out_pin,
  output logic                 seconds_tick,
  output logic                 osc_adjust_clear,
  output logic                 voltage_threshold_select,
  output logic                 test_mode,
  output logic                 hour_24_mode
);

  if (DIV_WIDTH < 9 || DIV_WIDTH > 24 || ADJ_MAX_TICKS > 128) begin : g_chk
    $error("divider width or adjustment range not supported");
  end

  // ------------------------------------------------------------------
  // Pin synchronisers and crystal edge
  // ------------------------------------------------------------------
  logic [5:0] pin_m_q;
  logic [5:0] pin_s_q;
  logic       xtal_prev_q;
  logic       xtal_s, clock_out_control_pin_s, ce_s, halt_s, lo21_s, lo16_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_m_q <= 6'h00;
      pin_s_q <= 6'h00;
    end else begin
      pin_m_q <= {xtal_clk_pin, clock_out_control_pin, chip_enable_pin,
                  osc_halt_sense_pin, supply_below_2v1_pin, supply_below_1v6_pin};
      pin_s_q <= pin_m_q;
    end
  end

  assign {xtal_s, clock_out_control_pin_s, ce_s, halt_s, lo21_s, lo16_s} = pin_s_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      xtal_prev_q <= 1'b0;
    end else begin
      xtal_prev_q <= xtal_s;
    end
  end

  // ------------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------------
  rtccs_ctrl_one_t ctrl_one_q;
  rtccs_ctrl_two_t wr2;
  rtccs_ctrl_two_t rd2;
  logic            wr_sec, wr_one, wr_two;
  logic            vts_q, lowv_q, scratch_q, halt_q, dis_a_q;
  logic            halt_event, lowv_event;
  logic            periodic_active, wflag, dflag;
  logic [7:0]      rdata_q;

  assign wr2    = rtccs_ctrl_two_t'(reg_req.wdata);
  assign wr_sec = reg_req.wr && reg_req.addr == RTCCS_ADDR_SECONDS;
  assign wr_one = reg_req.wr && reg_req.addr == RTCCS_ADDR_CTRL_ONE;
  assign wr_two = reg_req.wr && reg_req.addr == RTCCS_ADDR_CTRL_TWO;

  // The detector is blind while the serial link is selected.
  assign halt_event = !ce_s && halt_s;
  assign lowv_event = !lowv_q && (vts_q ? lo16_s : lo21_s);

  // ------------------------------------------------------------------
  // Control register one
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || halt_event) begin
      ctrl_one_q <= RTCCS_CTRL_ONE_RST;
    end else if (wr_one) begin
      ctrl_one_q <= rtccs_ctrl_one_t'(reg_req.wdata);
    end
  end

  // ------------------------------------------------------------------
  // Control and status register two
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || halt_event) begin
      vts_q     <= RTCCS_CTRL_TWO_RST.voltage_threshold_select;
      scratch_q <= RTCCS_CTRL_TWO_RST.scratch;
      dis_a_q   <= RTCCS_CTRL_TWO_RST.clock_out_disable_a;
    end else if (wr_two) begin
      vts_q     <= wr2.voltage_threshold_select;
      scratch_q <= wr2.scratch;
      dis_a_q   <= wr2.clock_out_disable_a;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || halt_event) begin
      lowv_q <= RTCCS_CTRL_TWO_RST.low_voltage_flag;
    end else if (lowv_event) begin
      lowv_q <= 1'b1;
    end else if (wr_two && !wr2.low_voltage_flag) begin
      lowv_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      halt_q <= RTCCS_CTRL_TWO_RST.oscillator_halt_flag;
    end else if (halt_event) begin
      halt_q <= 1'b1;
    end else if (wr_two && !wr2.oscillator_halt_flag) begin
      halt_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      osc_adjust_clear <= 1'b0;
    end else begin
      osc_adjust_clear <= halt_event;
    end
  end

  // ------------------------------------------------------------------
  // Sub-second divider with adjustment
  // ------------------------------------------------------------------
  logic [DIV_WIDTH-1:0] div_q;
  logic [7:0]           pause_q;
  logic [7:0]           adj_raw, adj_mag;
  logic [3:0]           sec_dly_q;
  logic [4:0]           sec20_q;
  logic                 step, second_edge, adj_now, tick_seen_q;

  // Test mode runs the divider on every system clock.
  assign step        = ctrl_one_q.test_mode ? 1'b1 : (xtal_s && !xtal_prev_q);
  assign second_edge = step && pause_q == 8'h00 && (&div_q) && !wr_sec;
  assign adj_now     = adj_active && sec20_q == 5'h00;
  assign adj_raw     = adj_ticks[7] ? 8'(-adj_ticks) : adj_ticks;
  assign adj_mag     = (adj_raw > 8'(ADJ_MAX_TICKS)) ? 8'(ADJ_MAX_TICKS) : adj_raw;

  // A positive step stalls the divider at zero, stretching the low phase;
  // a negative one skips counts at the start of the low phase.
  always_ff @(posedge clk) begin
    if (rst || wr_sec) begin
      div_q   <= '0;
      pause_q <= 8'h00;
    end else if (step && pause_q != 8'h00) begin
      pause_q <= pause_q - 8'h01;
    end else if (second_edge) begin
      div_q   <= (adj_now && adj_ticks[7]) ?
                 {{(DIV_WIDTH-8){1'b0}}, adj_mag} : '0;
      pause_q <= (adj_now && !adj_ticks[7]) ? adj_mag : 8'h00;
    end else if (step) begin
      div_q <= div_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || wr_sec) begin
      sec_dly_q <= 4'h0;
    end else if (second_edge) begin
      sec_dly_q <= 4'(RTCCS_SEC_DELAY_TICKS);
    end else if (step && sec_dly_q != 4'h0) begin
      sec_dly_q <= sec_dly_q - 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      seconds_tick <= 1'b0;
      tick_seen_q  <= 1'b0;
    end else begin
      seconds_tick <= step && sec_dly_q == 4'h1 && !wr_sec;
      tick_seen_q  <= seconds_tick;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sec20_q <= 5'h00;
    end else if (seconds_tick) begin
      sec20_q <= (sec20_q == 5'(RTCCS_ADJ_PERIOD_S - 1)) ? 5'h00 : sec20_q + 5'h01;
    end
  end

  // ------------------------------------------------------------------
  // Periodic interrupt
  // ------------------------------------------------------------------
  logic lvl_q, lvl_hit, is_level;

  assign is_level = ctrl_one_q.periodic_select >= RTCCS_PER_SEC;

  // Calendar levels settle one clock after the seconds tick, hence tick_seen_q.
  always_comb begin
    case (ctrl_one_q.periodic_select)
      RTCCS_PER_SEC:   lvl_hit = 1'b1;
      RTCCS_PER_MIN:   lvl_hit = cal.second_zero;
      RTCCS_PER_HOUR:  lvl_hit = cal.second_zero && cal.minute_zero;
      RTCCS_PER_MONTH: lvl_hit = (&cal);
      default:         lvl_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst || halt_event || !is_level) begin
      lvl_q <= 1'b0;
    end else if (tick_seen_q && lvl_hit) begin
      lvl_q <= 1'b1;
    end else if (wr_two && !wr2.periodic_interrupt_flag) begin
      lvl_q <= 1'b0;
    end
  end

  always_comb begin
    case (ctrl_one_q.periodic_select)
      RTCCS_PER_OFF: periodic_active = 1'b0;
      RTCCS_PER_LOW: periodic_active = 1'b1;
      RTCCS_PER_2HZ: periodic_active = !div_q[DIV_WIDTH-2];
      RTCCS_PER_1HZ: periodic_active = !div_q[DIV_WIDTH-1];
      default:       periodic_active = lvl_q;
    endcase
  end

  // ------------------------------------------------------------------
  // Alarm flags
  // ------------------------------------------------------------------
  rtccs_alarm_flag #(.DELAY_TICKS(RTCCS_ALARM_DLY_TICKS)) u_weekly (
    .clk       (clk),
    .rst       (rst),
    .step      (step),
    .match     (weekly_alarm_match),
    .enable    (ctrl_one_q.weekly_alarm_enable),
    .kill      (halt_event),
    .clear_req (wr_two && !wr2.weekly_alarm_flag),
    .flag      (wflag)
  );

  rtccs_alarm_flag #(.DELAY_TICKS(RTCCS_ALARM_DLY_TICKS)) u_daily (
    .clk       (clk),
    .rst       (rst),
    .step      (step),
    .match     (daily_alarm_match),
    .enable    (ctrl_one_q.daily_alarm_enable),
    .kill      (halt_event),
    .clear_req (wr_two && !wr2.daily_alarm_flag),
    .flag      (dflag)
  );

  // ------------------------------------------------------------------
  // Pins and read port
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      interrupt_out_pin     <= 1'b1;
      crystal_clock_out_pin <= 1'b0;
    end else begin
      interrupt_out_pin     <= !(periodic_active || wflag || dflag);
      crystal_clock_out_pin <= xtal_s && clock_out_control_pin_s &&
                               !(dis_a_q && ctrl_one_q.clock_out_disable_b);
    end
  end

  assign voltage_threshold_select = vts_q;
  assign test_mode                = ctrl_one_q.test_mode;
  assign hour_24_mode             = ctrl_one_q.hour_24;

  always_comb begin
    rd2 = '{voltage_threshold_select: vts_q, low_voltage_flag: lowv_q,
            scratch: scratch_q, oscillator_halt_flag: halt_q,
            clock_out_disable_a: dis_a_q,
            periodic_interrupt_flag: periodic_active,
            weekly_alarm_flag: wflag, daily_alarm_flag: dflag};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= RTCCS_RD_UNMAPPED;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        RTCCS_ADDR_CTRL_ONE: rdata_q <= ctrl_one_q;
        RTCCS_ADDR_CTRL_TWO: rdata_q <= rd2;
        default:             rdata_q <= RTCCS_RD_UNMAPPED;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence sec_write_1hz;
    wr_sec && ctrl_one_q.periodic_select == RTCCS_PER_1HZ && !wr_one && !halt_event;
  endsequence

  sequence divider_cleared;
    div_q == '0 ##1 !interrupt_out_pin;
  endsequence

  chk_clkout_gate: assert property (
    (dis_a_q && ctrl_one_q.clock_out_disable_b) || !clock_out_control_pin_s |=> !crystal_clock_out_pin)
    else $error("clock output not held low while disabled");

  chk_fixed_low: assert property (
    ctrl_one_q.periodic_select == RTCCS_PER_LOW |=> !interrupt_out_pin)
    else $error("fixed-low select did not drive the pin low");

  chk_pulse_1hz: assert property (
    ctrl_one_q.periodic_select == RTCCS_PER_1HZ && !wflag && !dflag
    |=> interrupt_out_pin == $past(div_q[DIV_WIDTH-1]))
    else $error("1 Hz output does not follow the divider");

  chk_sec_write: assert property (
    sec_write_1hz |=> divider_cleared)
    else $error("seconds write did not clear divider and drive low");

  chk_halt_clears: assert property (
    halt_event |=> halt_q && ctrl_one_q == RTCCS_CTRL_ONE_RST && !scratch_q && !lowv_q)
    else $error("halt did not clear the control registers");

  chk_halt_sticky: assert property (
    halt_q && !(wr_two && !wr2.oscillator_halt_flag) |=> halt_q)
    else $error("halt flag dropped without a clearing write");

  chk_lowv_sticky: assert property (
    lowv_q && !halt_event && !(wr_two && !wr2.low_voltage_flag) |=> lowv_q)
    else $error("low-voltage flag dropped without a clearing write");

  chk_level_release: assert property (
    is_level && wr_two && !wr2.periodic_interrupt_flag && !tick_seen_q && !wr_one
    |=> !lvl_q ##1 (interrupt_out_pin || wflag || dflag || $past(wflag || dflag)))
    else $error("level interrupt not released by clearing write");

  chk_interrupt_out_pin_any: assert property (
    periodic_active || wflag || dflag |=> !interrupt_out_pin)
    else $error("interrupt pin high while a source is active");

endmodule // rtccs_top

// *** testbench/rtccs_host_model.sv ***
`timescale 1ns/1ps
module rtccs_host_model
  import rtccs_pkg::*;
(
  input  wire logic       clk,
  output rtccs_reg_req_t  reg_req,
  input  wire logic [7:0] reg_rdata
);
  // ------------------------------------------------------------
  // Register bus master
  // ------------------------------------------------------------
  // Idle address and data are inverted so a slave that ignores the strobes cannot pass.
  initial reg_req = '0;

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = (a == RTCCS_ADDR_CTRL_ONE) ? (d & 8'hf7) : d;
    @(posedge clk);
    reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req <= '{addr: ~a, wdata: ~v, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule // rtccs_host_model

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb
  import rtccs_pkg::*;
;
  localparam int unsigned DW = 9;
  logic           clk, rst, xtal, cpin, ce, sense, lo21, lo16, wam, dam;
  logic           ck_out, irq_n, tick, adj_clr, vsel, tmode, h24, adj_on;
  logic [7:0]     rdata, adj_val;
  rtccs_cal_t     cal;
  rtccs_reg_req_t req;
  int             errors, compares, n, h;
  // Rows: address, write data, expected read back.
  logic [19:0]    rows [6] = '{20'hf0000, 20'hfffa8, 20'hefff7, 20'he0000,
                               20'hf2020, 20'h55a00};

  rtccs_top #(.DIV_WIDTH(DW)) i_dut (
    .clk(clk), .rst(rst), .reg_req(req), .reg_rdata(rdata), .xtal_clk_pin(xtal),
    .clock_out_control_pin(cpin), .chip_enable_pin(ce), .osc_halt_sense_pin(sense),
    .supply_below_2v1_pin(lo21), .supply_below_1v6_pin(lo16), .cal(cal),
    .weekly_alarm_match(wam), .daily_alarm_match(dam), .adj_active(adj_on),
    .adj_ticks(adj_val), .crystal_clock_out_pin(ck_out), .interrupt_out_pin(irq_n),
    .seconds_tick(tick), .osc_adjust_clear(adj_clr), .voltage_threshold_select(vsel),
    .test_mode(tmode), .hour_24_mode(h24));
  rtccs_host_model i_host (.clk(clk), .reg_req(req), .reg_rdata(rdata));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // The crystal starts off phase so its edges never line up with clk.
  initial begin
    xtal = 1'b0;
    #13;
    forever #40 xtal = ~xtal;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_host.wr_reg(a, d);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    i_host.rd_reg(a, v);
    check(v, exp);
  endtask
  task automatic wait_clk(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic ckcount(output int c);
    c = 0;
    repeat (100) begin
      @(negedge clk);
      c += ck_out;
    end
  endtask
  task automatic span(input logic lvl, output int c);
    c = 0;
    while (irq_n === lvl && c < 20000) begin
      @(negedge clk);
      c++;
    end
  endtask
  task automatic wait_tick(output int c);
    c = 0;
    while (tick !== 1'b1 && c < 12000) begin
      @(negedge clk);
      c++;
    end
  endtask

  initial begin
    #380us;
    errors++;
    finish_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {rst, cpin, ce, sense, lo21, lo16, wam, dam} = 8'h80;
    cal = '0;
    adj_on = 1'b0;
    adj_val = 8'h10;
    errors = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wait_clk(2);
    check({ck_out, irq_n}, 2'b01);
    rdc(4'hf, 8'h10);
    rdc(4'he, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i][19:16], rows[i][15:8]);
      rdc(rows[i][19:16], rows[i][7:0]);
    end
    for (int i = 0; i < 8; i++) begin
      wr(4'he, {3'b000, i[2], 4'h0});
      wr(4'hf, {4'h0, i[1], 3'b000});
      @(posedge clk);
      cpin <= i[0];
      ckcount(n);
      check(n > 20 && n < 80, i[0] && !(i[2] && i[1]));
    end
    // Halt detection must wait for chip enable to drop.
    wr(4'he, 8'hf0);
    wr(4'hf, 8'h28);
    @(posedge clk);
    {ce, sense} <= 2'b11;
    wait_clk(10);
    rdc(4'hf, 8'h28);
    check({tmode, h24}, 2'b01);
    @(posedge clk);
    ce <= 1'b0;
    n = 0;
    while (adj_clr !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    check(n < 10, 1'b1);
    rdc(4'he, 8'h00);
    check({tmode, h24}, 2'b00);
    rdc(4'hf, 8'h10);
    ckcount(n);
    check(n > 20 && n < 80, 1'b1);
    @(posedge clk);
    sense <= 1'b0;
    wait_clk(6);
    wr(4'hf, 8'h10);
    rdc(4'hf, 8'h10);
    wr(4'hf, 8'h00);
    rdc(4'hf, 8'h00);
    @(posedge clk);
    lo21 <= 1'b1;
    wait_clk(6);
    @(posedge clk);
    lo21 <= 1'b0;
    wait_clk(6);
    rdc(4'hf, 8'h40);
    wr(4'hf, 8'h80);
    rdc(4'hf, 8'h80);
    check(vsel, 1'b1);
    @(posedge clk);
    lo21 <= 1'b1;
    wait_clk(6);
    rdc(4'hf, 8'h80);
    @(posedge clk);
    lo16 <= 1'b1;
    wait_clk(6);
    rdc(4'hf, 8'hc0);
    @(posedge clk);
    {lo21, lo16} <= 2'b00;
    wr(4'hf, 8'h00);
    wr(4'he, 8'h80);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      {wam, dam} <= i ? 2'b01 : 2'b10;
      @(posedge clk);
      {wam, dam} <= 2'b00;
      wait_clk(10);
      check(irq_n, 1'b1);
      wait_clk(60);
      check(irq_n, i[0]);
      rdc(4'hf, i ? 8'h00 : 8'h02);
      wr(4'hf, 8'h00);
      wait_clk(3);
      check(irq_n, 1'b1);
    end
    for (int c = 2; c < 4; c++) begin
      h = 20 * (2 ** (DW - 1)) / (4 - c);
      // The first wrap since reset falls in the 1 Hz pass, at twenty-second slot zero.
      @(posedge clk);
      adj_on <= (c == 3);
      wr(4'he, c[7:0]);
      wr(4'h0, 8'h00);
      wait_clk(3);
      check(irq_n, 1'b0);
      span(1'b0, n);
      check(n > h - 40 && n < h + 40, 1'b1);
      span(1'b1, n);
      check(n > h - 40 && n < h + 40, 1'b1);
      if (c == 3) begin
        wait_tick(n);
        check(n > 40 && n < 80, 1'b1);
        span(1'b0, n);
        check(n > h + 16 * 20 - 100 && n < h + 16 * 20 - 20, 1'b1);
        @(posedge clk);
        adj_on <= 1'b0;
      end
    end
    // The last pass selects once per minute off second zero and must stay quiet.
    for (int c = 4; c < 9; c++) begin
      wr(4'he, c < 8 ? c[7:0] : 8'h05);
      @(posedge clk);
      cal <= (c < 8) ? 4'hf : 4'h0;
      wait_tick(n);
      check(irq_n, 1'b1);
      wait_clk(5);
      check(irq_n, c > 7);
      rdc(4'hf, c < 8 ? 8'h04 : 8'h00);
      wr(4'hf, 8'h00);
      wait_clk(3);
      check(irq_n, 1'b1);
    end
    wr(4'he, 8'h01);
    wait_clk(3);
    check(irq_n, 1'b0);
    rdc(4'hf, 8'h04);
    wr(4'he, 8'h00);
    wait_clk(3);
    check(irq_n, 1'b1);
    finish_test();
  end
endmodule // tb
